/* fpc_pkg.sv */
// Constants, field positions and types for the flash program control block.
// Assumes a single 200 MHz core clock domain.
package fpc_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] FPC_FLASH_CONTROL_ADDR = 8'hD1;
  localparam logic [7:0] FPC_CTRL_RESET = 8'h00;
  localparam int FPC_KEY_HI = 7;
  localparam int FPC_KEY_LO = 4;
  localparam int FPC_MAP_BIT = 3;
  localparam int FPC_SEL_HI = 2;
  localparam int FPC_SEL_LO = 1;
  localparam int FPC_BUSY_BIT = 0;
  localparam logic [3:0] FPC_KEY_UNLOCK = 4'h5;
  localparam logic [3:0] FPC_KEY_LAUNCH = 4'hA;
  // ----------------------------------------------------------------
  // Spaces and geometry
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FPC_SPACE_USER = 2'b00,
    FPC_SPACE_EXTRA = 2'b01,
    FPC_SPACE_SECURITY = 2'b10,
    FPC_SPACE_RESERVED = 2'b11
  } fpc_space_t;
  localparam logic [15:0] FPC_EXTRA_BASE = 16'hFF80;
  localparam logic [15:0] FPC_SECURITY_ADDR = 16'h0000;
  localparam int FPC_PAGE_BYTES = 128;
  localparam int FPC_PAGE_COUNT = 256;
  localparam int FPC_OFS_W = 7;
  localparam int FPC_PAGE_W = 8;
  localparam logic [7:0] FPC_ERASED = 8'hFF;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int FPC_CLK_MHZ = 200;
  localparam int FPC_PROG_TIME_MS = 10;
  localparam int FPC_PROG_CYCLES = FPC_PROG_TIME_MS * 1000 * FPC_CLK_MHZ;
  typedef enum logic [1:0] {
    FPC_ST_IDLE = 2'b00,
    FPC_ST_ERASE = 2'b01,
    FPC_ST_WRITE = 2'b10,
    FPC_ST_WAIT = 2'b11
  } fpc_state_t;
endpackage : fpc_pkg

/* fpc_flash_program_control.sv */
// Flash program control: the flash_control special-function register,
// column latches, launch sequencer and the flash arrays it programs.
// Assumes the CPU core presents one-cycle sfr and data-space write strobes.
`timescale 1ns/100ps
module fpc_flash_program_control
  import fpc_pkg::*;
#(
  parameter int PROG_CYCLES = FPC_PROG_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Special-function register port
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Data-space writes (external data move)
  input wire logic xdata_wr,
  input wire logic [15:0] xdata_addr,
  input wire logic [7:0] xdata_wdata,
  output logic xdata_to_ram,
  // Code-space byte read (code byte move)
  input wire logic [15:0] code_addr,
  output logic [7:0] code_rdata,
  // Core control
  output logic cpu_idle
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] user_mem [FPC_PAGE_COUNT*FPC_PAGE_BYTES];
  logic [7:0] extra_mem [FPC_PAGE_BYTES];
  logic [7:0] security_q;
  logic [7:0] latch_q [FPC_PAGE_BYTES];
  logic [FPC_PAGE_BYTES-1:0] loaded_q;

  logic [3:0] key_q;
  logic map_q;
  logic [1:0] sel_q;
  logic busy_q;
  logic armed_q;
  logic [FPC_PAGE_W-1:0] page_q;
  fpc_space_t space_q;
  fpc_state_t state_q;
  logic [31:0] cnt_q;
  logic [7:0] code_q;
  logic [FPC_OFS_W:0] idx_q;

  logic ctrl_wr;
  logic launch;
  logic latch_ok;
  assign ctrl_wr = sfr_wr && (sfr_addr == FPC_FLASH_CONTROL_ADDR);
  // Launch only from an armed unlock, a legal space and an idle array
  assign launch = ctrl_wr && armed_q && !busy_q &&
                  (sfr_wdata[FPC_KEY_HI:FPC_KEY_LO] == FPC_KEY_LAUNCH) &&
                  (sfr_wdata[FPC_SEL_HI:FPC_SEL_LO] != FPC_SPACE_RESERVED);

  function automatic logic in_extra(input logic [15:0] a);
    in_extra = (a >= FPC_EXTRA_BASE);
  endfunction : in_extra

  // Extra-row space only takes its own window; the security space only 0000h
  always_comb begin
    unique case (fpc_space_t'(sel_q))
      FPC_SPACE_EXTRA: latch_ok = in_extra(xdata_addr);
      FPC_SPACE_SECURITY: latch_ok = (xdata_addr == FPC_SECURITY_ADDR);
      FPC_SPACE_USER: latch_ok = 1'b1;
      FPC_SPACE_RESERVED: latch_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      key_q <= '0;
      map_q <= 1'b0;
      sel_q <= '0;
      armed_q <= 1'b0;
    end else if (ctrl_wr) begin
      key_q <= sfr_wdata[FPC_KEY_HI:FPC_KEY_LO];
      map_q <= sfr_wdata[FPC_MAP_BIT];
      sel_q <= sfr_wdata[FPC_SEL_HI:FPC_SEL_LO];
      // Any flash_control write other than the unlock drops the arming
      armed_q <= (sfr_wdata[FPC_KEY_HI:FPC_KEY_LO] == FPC_KEY_UNLOCK);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sfr_rdata <= FPC_CTRL_RESET;
    end else begin
      sfr_rdata <= {key_q, map_q, sel_q, busy_q};
    end
  end

  // ----------------------------------------------------------------
  // Column latches
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      loaded_q <= '0;
      page_q <= '0;
    end else if (state_q == FPC_ST_WAIT && cnt_q == 32'h0) begin
      loaded_q <= '0;
    end else if (xdata_wr && map_q && latch_ok && !busy_q) begin
      loaded_q[xdata_addr[FPC_OFS_W-1:0]] <= 1'b1;
      page_q <= xdata_addr[FPC_OFS_W+FPC_PAGE_W-1:FPC_OFS_W];
    end
  end

  always_ff @(posedge clk) begin
    if (xdata_wr && map_q && latch_ok && !busy_q) begin
      latch_q[xdata_addr[FPC_OFS_W-1:0]] <= xdata_wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      xdata_to_ram <= 1'b0;
    end else begin
      xdata_to_ram <= xdata_wr && !map_q;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer: erase pass, write pass, then hold until the program time from launch is up
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= FPC_ST_IDLE;
      busy_q <= 1'b0;
      cnt_q <= '0;
      idx_q <= '0;
      space_q <= FPC_SPACE_USER;
      cpu_idle <= 1'b0;
    end else begin
      unique case (state_q)
        FPC_ST_IDLE: begin
          if (launch) begin
            state_q <= FPC_ST_ERASE;
            busy_q <= 1'b1;
            cpu_idle <= 1'b1;
            space_q <= fpc_space_t'(sfr_wdata[FPC_SEL_HI:FPC_SEL_LO]);
            idx_q <= '0;
          end
        end
        FPC_ST_ERASE: begin
          idx_q <= idx_q + 1'b1;
          if (idx_q == (FPC_OFS_W+1)'(FPC_PAGE_BYTES - 1)) begin
            state_q <= FPC_ST_WRITE;
            idx_q <= '0;
          end
        end
        FPC_ST_WRITE: begin
          idx_q <= idx_q + 1'b1;
          if (idx_q == (FPC_OFS_W+1)'(FPC_PAGE_BYTES - 1)) begin
            state_q <= FPC_ST_WAIT;
            cnt_q <= 32'(PROG_CYCLES - 2 * FPC_PAGE_BYTES - 1);
          end
        end
        FPC_ST_WAIT: begin
          if (cnt_q == 32'h0) begin
            state_q <= FPC_ST_IDLE;
            busy_q <= 1'b0;
            cpu_idle <= 1'b0;
          end else begin
            cnt_q <= cnt_q - 32'h1;
          end
        end
      endcase
    end
  end

  // Only loaded locations are erased then written, within one page
  logic [FPC_OFS_W-1:0] ofs;
  logic [FPC_OFS_W+FPC_PAGE_W-1:0] uaddr;
  assign ofs = idx_q[FPC_OFS_W-1:0];
  assign uaddr = {page_q, ofs};

  always_ff @(posedge clk) begin
    if ((state_q == FPC_ST_ERASE || state_q == FPC_ST_WRITE) && loaded_q[ofs]) begin
      unique case (space_q)
        FPC_SPACE_USER: user_mem[uaddr] <=
          (state_q == FPC_ST_ERASE) ? FPC_ERASED : latch_q[ofs];
        FPC_SPACE_EXTRA: extra_mem[ofs] <=
          (state_q == FPC_ST_ERASE) ? FPC_ERASED : latch_q[ofs];
        FPC_SPACE_SECURITY: security_q <=
          (state_q == FPC_ST_ERASE) ? FPC_ERASED : latch_q[ofs];
        FPC_SPACE_RESERVED: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Code-space read, one cycle, no stall
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      code_q <= '0;
    end else begin
      unique case (fpc_space_t'(sel_q))
        FPC_SPACE_USER: code_q <=
          user_mem[code_addr[FPC_OFS_W+FPC_PAGE_W-1:0]];
        FPC_SPACE_EXTRA: code_q <= in_extra(code_addr) ?
          extra_mem[code_addr[FPC_OFS_W-1:0]] : FPC_ERASED;
        FPC_SPACE_SECURITY: code_q <= (code_addr == FPC_SECURITY_ADDR) ?
          security_q : FPC_ERASED;
        FPC_SPACE_RESERVED: code_q <= FPC_ERASED;
      endcase
    end
  end
  assign code_rdata = code_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence unlock_s;
    ctrl_wr && sfr_wdata[FPC_KEY_HI:FPC_KEY_LO] == FPC_KEY_UNLOCK;
  endsequence
  sequence launch_s;
    ctrl_wr && sfr_wdata[FPC_KEY_HI:FPC_KEY_LO] == FPC_KEY_LAUNCH &&
      sfr_wdata[FPC_SEL_HI:FPC_SEL_LO] != FPC_SPACE_RESERVED && !busy_q;
  endsequence

  launch_sets_busy_a: assert property (@(posedge clk) disable iff (!nrst)
    unlock_s ##1 !ctrl_wr ##1 launch_s |=> busy_q && cpu_idle)
    else $error("launch sequence did not start programming");
  no_skip_launch_a: assert property (@(posedge clk) disable iff (!nrst)
    !armed_q && !busy_q ##1 !busy_q |-> !(state_q == FPC_ST_ERASE))
    else $error("programming started without unlock");
  reserved_no_op_a: assert property (@(posedge clk) disable iff (!nrst)
    ctrl_wr && sfr_wdata[FPC_SEL_HI:FPC_SEL_LO] == FPC_SPACE_RESERVED && !busy_q
      |=> !busy_q)
    else $error("reserved space launched");
  busy_holds_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(busy_q) |-> busy_q [*8])
    else $error("busy dropped early");
  busy_ignore_a: assert property (@(posedge clk) disable iff (!nrst)
    busy_q && state_q == FPC_ST_WAIT && cnt_q != 32'h0 |=> busy_q)
    else $error("busy cleared before completion");
  busy_reg_bit_a: assert property (@(posedge clk) disable iff (!nrst)
    ##1 sfr_rdata[FPC_BUSY_BIT] == $past(busy_q))
    else $error("busy bit not reflected");
  idle_follows_a: assert property (@(posedge clk) disable iff (!nrst)
    cpu_idle == busy_q)
    else $error("core idle not tied to busy");
  extra_range_a: assert property (@(posedge clk) disable iff (!nrst)
    xdata_wr && map_q && sel_q == FPC_SPACE_EXTRA && !in_extra(xdata_addr) && !busy_q
      |=> $stable(loaded_q))
    else $error("extra row latch loaded out of range");
  map_ram_a: assert property (@(posedge clk) disable iff (!nrst)
    xdata_wr && map_q |=> !xdata_to_ram)
    else $error("mapped write reached ram");

  // Busy cycle count, only for the span check: a repetition cannot reach the program time
  logic [31:0] busy_len_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_len_q <= '0;
    end else if (busy_q) begin
      busy_len_q <= busy_len_q + 32'h1;
    end else begin
      busy_len_q <= '0;
    end
  end

  busy_span_a: assert property (@(posedge clk) disable iff (!nrst)
    $fell(busy_q) |-> busy_len_q == 32'(PROG_CYCLES))
    else $error("busy span differs from the program time");
  sec_range_a: assert property (@(posedge clk) disable iff (!nrst)
    xdata_wr && map_q && sel_q == FPC_SPACE_SECURITY &&
      xdata_addr != FPC_SECURITY_ADDR && !busy_q |=> $stable(loaded_q))
    else $error("security latch loaded off its address");
  reserved_read_a: assert property (@(posedge clk) disable iff (!nrst)
    sel_q == FPC_SPACE_RESERVED |=> code_rdata == FPC_ERASED)
    else $error("reserved space read returned data");
  extra_read_a: assert property (@(posedge clk) disable iff (!nrst)
    sel_q == FPC_SPACE_EXTRA && !in_extra(code_addr) |=> code_rdata == FPC_ERASED)
    else $error("extra row read outside its window");
endmodule : fpc_flash_program_control

/* fpc_cpu_model.sv */
// Behavioural CPU core driving the flash control block's sfr, data and code ports.
// Assumes the bench calls one task at a time, all on the rising edge of clk.
`timescale 1ns/100ps
module fpc_cpu_model
  import fpc_pkg::*;
(
  // Clock
  input wire logic clk,
  // Writes
  output logic sfr_wr,
  output logic [7:0] sfr_addr,
  output logic [7:0] sfr_wdata,
  output logic xdata_wr,
  output logic [15:0] xdata_addr,
  output logic [7:0] xdata_wdata,
  // Code read
  output logic [15:0] code_addr
);
  initial begin
    sfr_wr = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    xdata_wr = 1'b0;
    xdata_addr = 16'h0000;
    xdata_wdata = 8'h00;
    code_addr = 16'h0000;
  end
  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  // Released lines show the inverse so stale values never pass
  task automatic sfr_write_at(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(posedge clk);
    #1;
    sfr_wr = 1'b0;
    sfr_addr = ~a;
    sfr_wdata = ~d;
  endtask : sfr_write_at
  task automatic sfr_write(input logic [7:0] d);
    sfr_write_at(FPC_FLASH_CONTROL_ADDR, d);
  endtask : sfr_write
  task automatic xdata_write(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    xdata_wr = 1'b1;
    xdata_addr = a;
    xdata_wdata = d;
    @(posedge clk);
    #1;
    xdata_wr = 1'b0;
    xdata_addr = ~a;
    xdata_wdata = ~d;
  endtask : xdata_write
  // Key 5 then key A, space field kept; no interrupts exist here to mask
  task automatic launch(input logic [1:0] sp);
    sfr_write({FPC_KEY_UNLOCK, 1'b0, sp, 1'b0});
    sfr_write({FPC_KEY_LAUNCH, 1'b0, sp, 1'b0});
  endtask : launch
  task automatic code_read(input logic [15:0] a);
    @(posedge clk);
    #1;
    code_addr = a;
    @(posedge clk);
    #1;
  endtask : code_read
endmodule : fpc_cpu_model

/* tb_flash_program_control.sv */
// Self-checking bench for the flash program control block.
// Assumes the CPU model drives all bus inputs, the bench clk and nrst; busy time is shortened to PROG cycles.
`timescale 1ns/100ps
module tb_flash_program_control;
  import fpc_pkg::*;
  localparam int PROG = 300;
  logic clk;
  logic nrst;
  logic sfr_wr, xdata_wr, xdata_to_ram, cpu_idle;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, xdata_wdata, code_rdata;
  logic [15:0] xdata_addr, code_addr;
  int mismatches = 0;
  int n_checks = 0;
  fpc_cpu_model u_cpu (.clk(clk), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .xdata_wr(xdata_wr), .xdata_addr(xdata_addr),
    .xdata_wdata(xdata_wdata), .code_addr(code_addr));
  fpc_flash_program_control #(.PROG_CYCLES(PROG)) u_dut (.clk(clk), .nrst(nrst),
    .sfr_wr(sfr_wr), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .xdata_wr(xdata_wr), .xdata_addr(xdata_addr), .xdata_wdata(xdata_wdata),
    .xdata_to_ram(xdata_to_ram), .code_addr(code_addr), .code_rdata(code_rdata),
    .cpu_idle(cpu_idle));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      mismatches++;
    end
  endtask : chk
  task automatic end_of_test();
    if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    u_cpu.code_read(a);
    chk("code_rdata", code_rdata, exp);
  endtask : rd
  // Map on, good load, second load, launch, then watch busy across its span
  task automatic prog(input logic [1:0] sp, input logic [15:0] a, input logic [7:0] d,
                      input logic [15:0] b, input logic [7:0] e);
    u_cpu.sfr_write({4'h0, 1'b1, sp, 1'b0});
    u_cpu.xdata_write(a, d);
    u_cpu.xdata_write(b, e);
    u_cpu.launch(sp);
    repeat (3) @(posedge clk);
    #1;
    chk("busy", sfr_rdata[0], 1'b1);
    chk("cpu_idle", cpu_idle, 1'b1);
    u_cpu.sfr_write(8'h00);
    u_cpu.launch(sp);
    repeat (PROG - 30) @(posedge clk);
    #1;
    chk("busy held", sfr_rdata[0], 1'b1);
    // Launch edge lies 9 edges before the retry returned; busy spans PROG edges
    repeat (21) @(posedge clk);
    #1;
    chk("busy last", sfr_rdata[0], 1'b1);
    chk("idle done", cpu_idle, 1'b0);
    @(posedge clk);
    #1;
    chk("busy done", sfr_rdata[0], 1'b0);
  endtask : prog
  task automatic refuse(input logic [7:0] w0, input logic [7:0] w1, input logic [7:0] w2);
    u_cpu.sfr_write(w0);
    u_cpu.sfr_write(w1);
    u_cpu.sfr_write(w2);
    repeat (3) @(posedge clk);
    #1;
    chk("no launch", sfr_rdata[0], 1'b0);
  endtask : refuse
  // Foreign sfr write keeps the unlock; reset mid-busy clears control, busy and idle, arming too
  task automatic mid_reset();
    u_cpu.sfr_write(8'h08);
    u_cpu.xdata_write(16'h0200, 8'h21);
    u_cpu.sfr_write(8'h50);
    u_cpu.sfr_write_at(8'hD0, 8'h00);
    u_cpu.sfr_write(8'hA0);
    repeat (3) @(posedge clk);
    #1;
    chk("foreign kept", sfr_rdata[0], 1'b1);
    u_cpu.sfr_write(8'h50);
    repeat (2) @(posedge clk);
    #1;
    nrst = 1'b0;
    #1;
    chk("rst ctrl", sfr_rdata, FPC_CTRL_RESET);
    chk("rst idle", cpu_idle, 1'b0);
    repeat (4) @(posedge clk);
    #1;
    nrst = 1'b1;
    u_cpu.sfr_write(8'hA0);
    repeat (3) @(posedge clk);
    #1;
    chk("rst no launch", sfr_rdata, 8'hA0);
  endtask : mid_reset
  // ----------------------------------------------------------------
  // Clock, reset, sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #50000;
    mismatches++;
    end_of_test();
  end
  initial begin
    nrst = 1'b0;
    repeat (20) @(posedge clk);
    #1;
    nrst = 1'b1;
    chk("ctrl reset", sfr_rdata, FPC_CTRL_RESET);
    chk("idle reset", cpu_idle, 1'b0);
    // Extra row: low-address load aliases offset 05h and must be dropped
    prog(FPC_SPACE_EXTRA, 16'hFF85, 8'h12, 16'h0005, 8'h99);
    u_cpu.sfr_write(8'h02);
    rd(16'hFF85, 8'h12);
    // Security byte: only pointer 0000h is accepted
    prog(FPC_SPACE_SECURITY, 16'h0000, 8'h5A, 16'h0080, 8'h66);
    u_cpu.sfr_write(8'h04);
    rd(16'h0000, 8'h5A);
    rd(16'h0001, FPC_ERASED);
    // User array: page follows the last load, then overwrite needs self erase
    prog(FPC_SPACE_USER, 16'h0123, 8'h77, 16'h01A5, 8'h44);
    u_cpu.sfr_write(8'h00);
    rd(16'h01A3, 8'h77);
    rd(16'h01A5, 8'h44);
    prog(FPC_SPACE_USER, 16'h01A5, 8'h33, 16'h01A5, 8'h33);
    u_cpu.sfr_write(8'h00);
    rd(16'h01A5, 8'h33);
    rd(16'h01A3, 8'h77);
    u_cpu.sfr_write(8'h06);
    rd(16'hFF85, FPC_ERASED);
    // Refused launches
    refuse(8'h50, 8'h00, 8'hA0);
    refuse(8'h56, 8'hA6, 8'h06);
    refuse(8'hA0, 8'h00, 8'h00);
    mid_reset();
    // Map bit steers data-space writes
    u_cpu.sfr_write(8'h00);
    u_cpu.xdata_write(16'h1000, 8'h11);
    chk("to ram", xdata_to_ram, 1'b1);
    u_cpu.sfr_write(8'h08);
    @(posedge clk);
    #1;
    chk("ctrl map", sfr_rdata, 8'h08);
    u_cpu.xdata_write(16'h1000, 8'h11);
    chk("to latch", xdata_to_ram, 1'b0);
    end_of_test();
  end
endmodule : tb_flash_program_control
